//--- core/rlc_pkg.sv
// Package of register map, field layout and encodings for the reference ladder control
package rlc_pkg;
   // Register byte addresses on the register bus
   localparam logic [3:0] RLC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] RLC_ADDR_LEVEL   = 4'h4;
   localparam int         RLC_ADDR_WIDTH   = 4;
   // Field positions in the control register
   localparam int RLC_BIT_ENABLE  = 7;
   localparam int RLC_BIT_PIN_OE  = 5;
   localparam int RLC_BIT_UPPER_HI = 3;
   localparam int RLC_BIT_UPPER_LO = 2;
   localparam int RLC_BIT_LOWER   = 0;
   // Writable masks; other bits read as zero
   localparam logic [7:0] RLC_CONTROL_MASK = 8'hAD;
   localparam logic [7:0] RLC_LEVEL_MASK   = 8'h1F;
   // Reset values
   localparam logic [7:0] RLC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] RLC_LEVEL_RESET   = 8'h00;
   // Level code width
   localparam int RLC_LEVEL_WIDTH = 5;
   // AXI responses
   localparam logic [1:0] RLC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RLC_RESP_SLVERR = 2'h2;
   // Upper ladder source encodings
   typedef enum logic [1:0] {
      RLC_UPPER_SUPPLY   = 2'b00,
      RLC_UPPER_EXT_REF  = 2'b01,
      RLC_UPPER_FIXED    = 2'b10,
      RLC_UPPER_RESERVED = 2'b11
   } rlc_upper_type;
   // Bus slave write channel state
   typedef enum logic [1:0] {
      RLC_WR_IDLE = 2'b00,
      RLC_WR_RESP = 2'b01
   } rlc_wr_state_type;
endpackage

//--- core/rlc_pin_override.sv
// Pin override logic for the reference output pin
`timescale 1ns/100ps
module rlc_pin_override (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Settings
   input  wire logic pin_output_enable,
   // Port logic requests
   input  wire logic port_out_value,
   input  wire logic port_out_enable,
   input  wire logic port_pull_up,
   input  wire logic port_current_drive,
   input  wire logic pin_in_raw,
   // Pin-facing outputs
   output logic      pin_out,
   output logic      pin_oe,
   output logic      pin_pull_up,
   output logic      pin_current_drive,
   output logic      pin_input_enable,
   output logic      pin_analog_connect,
   output logic      port_read_value
);
   wire logic next_oe;
   wire logic next_read;
   // Ladder on the pin overrides drivers and reads as zero
   assign next_oe   = port_out_enable & ~pin_output_enable;
   assign next_read = pin_in_raw & ~pin_output_enable;

   // Registered pin controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out            <= 1'b0;
         pin_oe             <= 1'b0;
         pin_pull_up        <= 1'b0;
         pin_current_drive  <= 1'b0;
         pin_input_enable   <= 1'b0;
         pin_analog_connect <= 1'b0;
         port_read_value    <= 1'b0;
      end else begin
         pin_out            <= port_out_value & next_oe;
         pin_oe             <= next_oe;
         pin_pull_up        <= port_pull_up & ~pin_output_enable;
         pin_current_drive  <= port_current_drive & ~pin_output_enable;
         pin_input_enable   <= ~pin_output_enable;
         pin_analog_connect <= pin_output_enable;
         port_read_value    <= next_read;
      end
   end
endmodule

//--- core/rlc_source_decode.sv
// Decoder of ladder source selects into one-hot switch controls
`timescale 1ns/100ps
module rlc_source_decode
   import rlc_pkg::*;
(
   // Settings
   input  wire rlc_pkg::rlc_upper_type upper_source_select,
   input  wire logic                   lower_source_select,
   input  wire logic                   converter_enable,
   // One-hot switch controls
   output logic [2:0]                  upper_switch,
   output logic [1:0]                  lower_switch
);
   // Upper source: supply, external, fixed; reserved code connects nothing
   always_comb begin
      upper_switch = 3'h0;
      if (converter_enable) begin
         case (upper_source_select)
            RLC_UPPER_SUPPLY:  upper_switch = 3'h1;
            RLC_UPPER_EXT_REF: upper_switch = 3'h2;
            RLC_UPPER_FIXED:   upper_switch = 3'h4;
            default:           upper_switch = 3'h0;
         endcase
      end
   end
   // Lower source: ground or external negative reference
   assign lower_switch = converter_enable ? (lower_source_select ? 2'h2 : 2'h1) : 2'h0;
endmodule

//--- core/rlc_top.sv
// Top of the reference ladder control: AXI4-Lite registers and ladder drive
//
// How it works
// - Enable bit seven turns converter on
// - Five-bit level code picks one of 32
// - Pin output enable connects ladder to pin
// - Ladder on pin overrides drivers and pulls
// - Pin reads zero while carrying ladder output
// - Upper source select chooses supply, external, fixed
// - Lower source select chooses ground or external
// - Sleep and wake keep settings intact
// - Reset clears every field to zero
// - Unimplemented bits read zero, writes ignored
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module rlc_top
   import rlc_pkg::*;
(
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [RLC_ADDR_WIDTH-1:0]  s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   // AXI4-Lite write response
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic [1:0]                      s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [RLC_ADDR_WIDTH-1:0]  s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   // AXI4-Lite read data
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   // Ladder and source multiplexers
   output logic                            converter_enable,
   output logic [RLC_LEVEL_WIDTH-1:0]      level_code,
   output logic [2:0]                      upper_switch,
   output logic [1:0]                      lower_switch,
   // Port logic requests for the reference output pin
   input  wire logic                       port_out_value,
   input  wire logic                       port_out_enable,
   input  wire logic                       port_pull_up,
   input  wire logic                       port_current_drive,
   input  wire logic                       pin_in_raw,
   // Reference output pin controls
   output logic                            pin_out,
   output logic                            pin_oe,
   output logic                            pin_pull_up,
   output logic                            pin_current_drive,
   output logic                            pin_input_enable,
   output logic                            pin_analog_connect,
   output logic                            port_read_value
);
   import rlc_pkg::*;

   // Register storage
   logic [7:0]         reference_control;
   logic [7:0]         reference_level;
   // Write channel capture
   rlc_wr_state_type   wr_state;
   logic               aw_held;
   logic               w_held;
   logic [RLC_ADDR_WIDTH-1:0] aw_addr;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic [2:0]         next_upper;
   logic [1:0]         next_lower;

   // Address decode as a function, used for both channels
   function automatic logic [1:0] rlc_decode(input logic [RLC_ADDR_WIDTH-1:0] addr);
      rlc_decode = 2'h0;
      if (addr == RLC_ADDR_CONTROL) rlc_decode = 2'h1;
      if (addr == RLC_ADDR_LEVEL)   rlc_decode = 2'h2;
   endfunction

   // Write decode wires
   wire logic       aw_take   = s_axi_awvalid & s_axi_awready;
   wire logic       w_take    = s_axi_wvalid & s_axi_wready;
   wire logic       have_aw   = aw_held | aw_take;
   wire logic       have_w    = w_held | w_take;
   wire logic [RLC_ADDR_WIDTH-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire logic [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
   wire logic       wr_lane0  = w_held ? w_strb[0] : s_axi_wstrb[0];
   wire logic       wr_fire   = (wr_state == RLC_WR_IDLE) & have_aw & have_w;
   wire logic [1:0] wr_sel    = rlc_decode(wr_addr);
   wire logic       wr_ctrl   = wr_fire & wr_sel[0] & wr_lane0;
   wire logic       wr_lvl    = wr_fire & wr_sel[1] & wr_lane0;
   wire logic [1:0] wr_resp   = (wr_sel == 2'h0) ? RLC_RESP_SLVERR : RLC_RESP_OKAY;

   // Write channel: take address and data in either order, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state      <= RLC_WR_IDLE;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RLC_RESP_OKAY;
      end else begin
         case (wr_state)
            RLC_WR_IDLE: begin
               if (aw_take) begin
                  aw_held <= 1'b1;
                  aw_addr <= s_axi_awaddr;
               end
               if (w_take) begin
                  w_held <= 1'b1;
                  w_data <= s_axi_wdata;
                  w_strb <= s_axi_wstrb;
               end
               s_axi_awready <= ~have_aw;
               s_axi_wready  <= ~have_w;
               if (wr_fire) begin
                  s_axi_awready <= 1'b0;
                  s_axi_wready  <= 1'b0;
                  s_axi_bvalid  <= 1'b1;
                  s_axi_bresp   <= wr_resp;
                  wr_state      <= RLC_WR_RESP;
               end
            end
            RLC_WR_RESP: begin
               aw_held <= 1'b0;
               w_held  <= 1'b0;
               if (s_axi_bready) begin
                  s_axi_bvalid  <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wr_state      <= RLC_WR_IDLE;
               end
            end
            default: begin
               wr_state <= RLC_WR_IDLE;
            end
         endcase
      end
   end

   // Settings registers; no sleep input exists, so sleep leaves them untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reference_control <= RLC_CONTROL_RESET;
         reference_level   <= RLC_LEVEL_RESET;
      end else begin
         if (wr_ctrl)
            reference_control <= wr_data[7:0] & RLC_CONTROL_MASK;
         if (wr_lvl)
            reference_level <= wr_data[7:0] & RLC_LEVEL_MASK;
      end
   end

   // Read decode wires
   wire logic [1:0]  rd_sel  = rlc_decode(s_axi_araddr);
   wire logic [7:0]  rd_byte = rd_sel[0] ? reference_control : (rd_sel[1] ? reference_level : 8'h00);
   wire logic        rd_take = s_axi_arvalid & s_axi_arready;

   // Read channel: one cycle after address taken, hold until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RLC_RESP_OKAY;
      end else begin
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= (rd_sel == 2'h0) ? RLC_RESP_SLVERR : RLC_RESP_OKAY;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Ladder drive follows the fields directly, one register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_enable <= 1'b0;
         level_code       <= '0;
         upper_switch     <= 3'h0;
         lower_switch     <= 2'h0;
      end else begin
         converter_enable <= reference_control[RLC_BIT_ENABLE];
         level_code       <= reference_level[RLC_LEVEL_WIDTH-1:0];
         upper_switch     <= next_upper;
         lower_switch     <= next_lower;
      end
   end

   // Source multiplexer decode; the reserved code is left unconnected
   rlc_source_decode u_source (
      .upper_source_select (rlc_upper_type'(reference_control[RLC_BIT_UPPER_HI:RLC_BIT_UPPER_LO])),
      .lower_source_select (reference_control[RLC_BIT_LOWER]),
      .converter_enable    (reference_control[RLC_BIT_ENABLE]),
      .upper_switch        (next_upper),
      .lower_switch        (next_lower)
   );

   // Reference output pin override
   rlc_pin_override u_pin (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .pin_output_enable  (reference_control[RLC_BIT_PIN_OE]),
      .port_out_value     (port_out_value),
      .port_out_enable    (port_out_enable),
      .port_pull_up       (port_pull_up),
      .port_current_drive (port_current_drive),
      .pin_in_raw         (pin_in_raw),
      .pin_out            (pin_out),
      .pin_oe             (pin_oe),
      .pin_pull_up        (pin_pull_up),
      .pin_current_drive  (pin_current_drive),
      .pin_input_enable   (pin_input_enable),
      .pin_analog_connect (pin_analog_connect),
      .port_read_value    (port_read_value)
   );
endmodule

//--- dv/rlc_assertions.sv
// Checker of ladder drive, pin override and register bus relations
`timescale 1ns/100ps
module rlc_assertions
   import rlc_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // Ladder drive
   input wire logic        converter_enable,
   input wire logic [4:0]  level_code,
   input wire logic [2:0]  upper_switch,
   input wire logic [1:0]  lower_switch,
   // Pin controls
   input wire logic        pin_oe,
   input wire logic        pin_pull_up,
   input wire logic        pin_current_drive,
   input wire logic        pin_input_enable,
   input wire logic        pin_analog_connect,
   input wire logic        port_read_value
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_RESET_CLEAR: assert property ($rose(aresetn) |-> !converter_enable && level_code == 5'h00 && !pin_analog_connect)
      else $error("Settings not cleared at reset release");
   AST_OFF_NO_SWITCH: assert property (!converter_enable |-> upper_switch == 3'h0 && lower_switch == 2'h0)
      else $error("Source switch closed while converter off");
   AST_UPPER_ONEHOT: assert property (upper_switch != 3'h0 |-> $onehot(upper_switch))
      else $error("Upper switches not one-hot");
   AST_LOWER_ONEHOT: assert property (converter_enable |-> $onehot(lower_switch))
      else $error("Lower switches not one-hot while enabled");
   AST_PIN_OVERRIDE: assert property (pin_analog_connect |-> !(pin_oe || pin_pull_up || pin_current_drive || pin_input_enable))
      else $error("Digital pin function active while ladder on pin");
   AST_PIN_DIGITAL: assert property (!pin_analog_connect && $past(aresetn) |-> pin_input_enable)
      else $error("Input detector off while pin is digital");
   AST_READ_ZERO: assert property (pin_analog_connect |-> port_read_value == 1'h0)
      else $error("Pin read not zero while ladder on pin");
   AST_LEVEL_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == RLC_ADDR_LEVEL && s_axi_wstrb[0] |-> ##2 level_code == $past(s_axi_wdata[4:0], 2))
      else $error("Level code did not follow write");
   AST_RDATA_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("Read data upper bits not zero");
   // Main scenarios
   COV_LEVEL: cover property (s_axi_wvalid && s_axi_wready && s_axi_awaddr == RLC_ADDR_LEVEL);
   COV_PIN: cover property (pin_analog_connect && converter_enable);
   COV_READ: cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule
bind rlc_top rlc_assertions i_chk (.*);

//--- dv/rlc_pad_model.sv
// Behavioural model of the reference pin pad seen from the block
`timescale 1ns/100ps
module rlc_pad_model (
   // Clock
   input wire logic aclk,
   // Switch state and external pad level
   input wire logic pin_analog_connect,
   input wire logic pad_level,
   // Pad input sense
   output logic     pin_in_raw
);
   logic toggle = 1'h0;
   // Ladder voltage is no logic level: the sense flips every cycle
   always @(posedge aclk) toggle <= ~toggle;
   assign pin_in_raw = pin_analog_connect ? toggle : pad_level;
endmodule

//--- dv/tb.sv
// Self-checking testbench of the reference ladder control
`timescale 1ns/100ps
module tb;
   import rlc_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, converter_enable, pin_in_raw, pad_level = 1'h0;
   logic        port_out_value = 1'h0, port_out_enable = 1'h0, port_pull_up = 1'h0, port_current_drive = 1'h0;
   logic        pin_out, pin_oe, pin_pull_up, pin_current_drive, pin_input_enable, pin_analog_connect, port_read_value;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, upper_switch;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, lower_switch, rsp, rrsp;
   logic [4:0]  level_code, lvl;
   int          n_fail = 0, tests_run = 0;
   typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] r; logic [6:0] o;} rlc_row_type;
   // Rows: address, written byte, read back, {pin, enable, upper, lower}; reserved upper code never written
   rlc_row_type rows [7] = '{'{4'h0, 8'h80, 8'h80, 7'h25}, '{4'h4, 8'hFF, 8'h1F, 7'h25},
      '{4'h0, 8'hF9, 8'hA9, 7'h72}, '{4'h0, 8'h85, 8'h85, 7'h2A}, '{4'h4, 8'h0A, 8'h0A, 7'h2A},
      '{4'h0, 8'h21, 8'h21, 7'h40}, '{4'h0, 8'h52, 8'h00, 7'h00}};
   rlc_top i_dut (.*);
   rlc_pad_model i_pad (.aclk(aclk), .pin_analog_connect(pin_analog_connect), .pad_level(pad_level), .pin_in_raw(pin_in_raw));
   // Clock of 10 ns
   always #5 aclk = ~aclk;
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'h1;
      s_axi_wdata <= v;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (i == 50) begin
         n_fail++;
         test_done();
      end
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      int i;
      @(posedge aclk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      v = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (i == 50) begin
         n_fail++;
         test_done();
      end
   endtask
   task automatic rst;
      aresetn <= 1'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
   endtask
   // Main sequence
   initial begin
      rst();
      rd(RLC_ADDR_CONTROL, d);
      chk(d, RLC_CONTROL_RESET);
      $display("Reset values done");
      lvl = 5'h00;
      foreach (rows[k]) begin
         wr(rows[k].a, {24'hFFFFFF, rows[k].w}, rsp);
         chk(rsp, RLC_RESP_OKAY);
         rd(rows[k].a, d);
         chk(d, rows[k].r);
         if (rows[k].a === RLC_ADDR_LEVEL) lvl = rows[k].r[4:0];
         chk({pin_analog_connect, converter_enable, upper_switch, lower_switch}, rows[k].o);
         chk(level_code, lvl);
         $display("Row %0d done", k);
      end
      wr(4'h8, 32'h000000FF, rsp);
      chk(rsp, RLC_RESP_SLVERR);
      rd(4'h8, d);
      chk(d, 32'h0);
      chk(rrsp, RLC_RESP_SLVERR);
      s_axi_wstrb <= 4'h0;
      wr(RLC_ADDR_LEVEL, 32'h1F, rsp);
      chk(rsp, RLC_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(RLC_ADDR_LEVEL, d);
      chk(d, 32'h0A);
      $display("Bus refusals done");
      port_pull_up <= 1'h1;
      port_current_drive <= 1'h1;
      port_out_enable <= 1'h1;
      port_out_value <= 1'h1;
      pad_level <= 1'h1;
      repeat (3) @(posedge aclk);
      chk({pin_out, pin_oe, pin_pull_up, pin_current_drive, pin_input_enable, port_read_value}, 6'h3F);
      wr(RLC_ADDR_CONTROL, 32'h20, rsp);
      repeat (3) @(posedge aclk);
      chk({pin_analog_connect, pin_out, pin_oe, pin_pull_up, pin_current_drive, pin_input_enable}, 6'h20);
      chk(port_read_value, 1'h0);
      $display("Pin override done");
      wr(RLC_ADDR_CONTROL, 32'hA9, rsp);
      wr(RLC_ADDR_LEVEL, 32'h1F, rsp);
      rst();
      chk({pin_analog_connect, converter_enable, upper_switch, lower_switch, level_code}, 12'h0);
      rd(RLC_ADDR_CONTROL, d);
      chk(d, RLC_CONTROL_RESET);
      rd(RLC_ADDR_LEVEL, d);
      chk(d, RLC_LEVEL_RESET);
      $display("Reset in run done");
      test_done();
   end
endmodule
